/* hw/uhpc_params.svh */
// constants of the usb host port control block
`ifndef UHPC_PARAMS_SVH
`define UHPC_PARAMS_SVH

// byte offsets on the register bus
`define UHPC_OFS_PORT       4'h0
`define UHPC_OFS_INT_STAT   4'h4
`define UHPC_OFS_INT_MASK   4'h8

// port register field positions
`define UHPC_B_CONN_STATE   0
`define UHPC_B_CONN_DET     1
`define UHPC_B_PORT_EN      2
`define UHPC_B_EN_CHG       3
`define UHPC_B_RESUME       6
`define UHPC_B_SUSPEND      7
`define UHPC_B_BUS_RESET    8
`define UHPC_B_LINE_DP      10
`define UHPC_B_LINE_DM      11
`define UHPC_B_POWER        12
`define UHPC_B_SPEED_LO     17

// attached speed codes
`define UHPC_SPEED_NONE     2'h0
`define UHPC_SPEED_FULL     2'h1
`define UHPC_SPEED_LOW      2'h2

// interrupt status and mask layout
`define UHPC_INT_W          3
`define UHPC_I_PORT_EVT     0
`define UHPC_I_DISCONNECT   1
`define UHPC_I_WAKEUP       2

`define UHPC_RESET_WORD     32'h0000_0000

// line timing
`define UHPC_CLK_MHZ        125
`define UHPC_CONN_DEB_NS    2500
`define UHPC_CONN_DEB_CYC   ((`UHPC_CONN_DEB_NS * `UHPC_CLK_MHZ + 999) / 1000)
`define UHPC_DISC_NS        2500
`define UHPC_DISC_CYC       ((`UHPC_DISC_NS * `UHPC_CLK_MHZ + 999) / 1000)

`endif

/* hw/uhpc_pkg.sv */
// types of the usb host port control block
package uhpc_pkg;

  typedef enum logic [2:0] {
    UHPC_LN_DETACHED = 3'b001,
    UHPC_LN_DEBOUNCE = 3'b010,
    UHPC_LN_ATTACHED = 3'b100
  } uhpc_line_state_t;

endpackage

/* hw/uhpc_line_monitor.sv */
// line monitor: connect, disconnect, speed and remote wakeup detection
`timescale 1ns/1ps
`include "uhpc_params.svh"

module uhpc_line_monitor
  import uhpc_pkg::*;
#(
  parameter int CNT_W    = 12,
  parameter int DEB_CYC  = `UHPC_CONN_DEB_CYC,
  parameter int DISC_CYC = `UHPC_DISC_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // line levels and port context
  input  wire logic       dp_in,
  input  wire logic       dm_in,
  input  wire logic       drive_active,
  input  wire logic       suspended,
  // results
  output logic            connected,
  output logic [1:0]      speed,
  output logic            conn_pulse,
  output logic            disc_pulse,
  output logic            wake_pulse
);

  uhpc_line_state_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0]       speed_ff, nxt_speed;
  logic             conn_p_ff, nxt_conn_p;
  logic             disc_p_ff, nxt_disc_p;
  logic             wake_p_ff, nxt_wake_p;
  logic             se0;
  logic             k_state;

  assign se0     = ~dp_in & ~dm_in;
  // k is the inverse of the idle level for the latched speed
  assign k_state = (speed_ff == `UHPC_SPEED_LOW) ? (dp_in & ~dm_in) : (~dp_in & dm_in);

  always_comb begin
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_speed  = speed_ff;
    nxt_conn_p = 1'b0;
    nxt_disc_p = 1'b0;
    nxt_wake_p = 1'b0;
    case (st_ff)
      UHPC_LN_DETACHED: begin
        nxt_cnt = '0;
        if (!se0 && !drive_active) begin
          nxt_st = UHPC_LN_DEBOUNCE;
        end
      end
      UHPC_LN_DEBOUNCE: begin
        if (se0 || drive_active) begin
          nxt_st  = UHPC_LN_DETACHED;
          nxt_cnt = '0;
        end else if (cnt_ff == CNT_W'(DEB_CYC - 1)) begin
          nxt_st     = UHPC_LN_ATTACHED;
          nxt_cnt    = '0;
          nxt_conn_p = 1'b1;
          nxt_speed  = dp_in ? `UHPC_SPEED_FULL : `UHPC_SPEED_LOW;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      UHPC_LN_ATTACHED: begin
        if (se0 && !drive_active) begin
          if (cnt_ff == CNT_W'(DISC_CYC - 1)) begin
            nxt_st     = UHPC_LN_DETACHED;
            nxt_cnt    = '0;
            nxt_disc_p = 1'b1;
            nxt_speed  = `UHPC_SPEED_NONE;
          end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
          end
        end else begin
          nxt_cnt = '0;
        end
        if (suspended && !drive_active && k_state) begin
          nxt_wake_p = 1'b1;
        end
      end
      default: begin
        nxt_st    = UHPC_LN_DETACHED;
        nxt_cnt   = '0;
        nxt_speed = `UHPC_SPEED_NONE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff     <= UHPC_LN_DETACHED;
      cnt_ff    <= '0;
      speed_ff  <= `UHPC_SPEED_NONE;
      conn_p_ff <= 1'b0;
      disc_p_ff <= 1'b0;
      wake_p_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      speed_ff  <= nxt_speed;
      conn_p_ff <= nxt_conn_p;
      disc_p_ff <= nxt_disc_p;
      wake_p_ff <= nxt_wake_p;
    end
  end

  assign connected  = (st_ff == UHPC_LN_ATTACHED);
  assign speed      = speed_ff;
  assign conn_pulse = conn_p_ff;
  assign disc_pulse = disc_p_ff;
  assign wake_pulse = wake_p_ff;

endmodule // uhpc_line_monitor

/* hw/uhpc_port_ctrl.sv */
// usb host port control and status logic with avalon-mm register slave
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "uhpc_params.svh"

module uhpc_port_ctrl
  import uhpc_pkg::*;
#(
  parameter int CNT_W    = 12,
  parameter int DEB_CYC  = `UHPC_CONN_DEB_CYC,
  parameter int DISC_CYC = `UHPC_DISC_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // usb data lines
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  output logic             dp_out,
  output logic             dm_out,
  output logic             d_oe_n,
  // port status to the frame logic
  output logic             sof_enable,
  output logic             port_power_on
);

  // bus handshake
  logic        ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wr_fire;
  logic        port_wr, stat_wr, mask_wr;

  // port state
  logic        port_enabled_ff, nxt_port_enabled;
  logic        enable_change_flag_ff, nxt_enable_change_flag;
  logic        connect_detected_flag_ff, nxt_connect_detected_flag;
  logic        resume_drive_ff, nxt_resume_drive;
  logic        port_suspend_ff, nxt_port_suspend;
  logic        bus_reset_drive_ff, nxt_bus_reset_drive;
  logic        power_ff, nxt_power;
  logic [`UHPC_INT_W-1:0] int_stat_ff, nxt_int_stat;
  logic [`UHPC_INT_W-1:0] int_mask_ff, nxt_int_mask;
  logic        irq_ff, nxt_irq;

  // line drive
  logic        dp_ff, nxt_dp;
  logic        dm_ff, nxt_dm;
  logic        oe_n_ff, nxt_oe_n;
  logic        sof_ff, nxt_sof;

  // monitor results
  logic        connect_state;
  logic [1:0]  attached_speed;
  logic        conn_pulse, disc_pulse, wake_pulse;
  logic        drive_active;
  logic        reset_done, reset_start, enable_change;

  // write-one strobes of the port register
  logic        w1_conn_det;
  logic        w1_port_en;
  logic        w1_en_chg;
  logic        w1_resume;
  logic        w1_suspend;
  logic        w1_bus_reset;

  // write-one test of a bit, honouring its byte lane
  function automatic logic wr_one(input logic sel, input logic [3:0] be,
                                  input logic [31:0] wd, input int bitn);
    return sel & be[bitn / 8] & wd[bitn];
  endfunction

  // lane-enabled write of a read-write bit
  function automatic logic wr_rw(input logic sel, input logic [3:0] be,
                                 input logic [31:0] wd, input int bitn, input logic cur);
    return (sel & be[bitn / 8]) ? wd[bitn] : cur;
  endfunction

  uhpc_line_monitor #(
    .CNT_W    (CNT_W),
    .DEB_CYC  (DEB_CYC),
    .DISC_CYC (DISC_CYC)
  ) u_monitor (
    .clk          (clk),
    .rst          (rst),
    .dp_in        (dp_in),
    .dm_in        (dm_in),
    .drive_active (drive_active),
    .suspended    (port_suspend_ff),
    .connected    (connect_state),
    .speed        (attached_speed),
    .conn_pulse   (conn_pulse),
    .disc_pulse   (disc_pulse),
    .wake_pulse   (wake_pulse)
  );

  assign drive_active = ~oe_n_ff;

  // register bus: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_fire         = avs_write & ack_ff;
  assign port_wr         = wr_fire & (avs_address == `UHPC_OFS_PORT);
  assign stat_wr         = wr_fire & (avs_address == `UHPC_OFS_INT_STAT);
  assign mask_wr         = wr_fire & (avs_address == `UHPC_OFS_INT_MASK);

  // write-one strobes, each gated by its byte lane
  assign w1_conn_det  = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_CONN_DET);
  assign w1_port_en   = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_PORT_EN);
  assign w1_en_chg    = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_EN_CHG);
  assign w1_resume    = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_RESUME);
  assign w1_suspend   = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_SUSPEND);
  assign w1_bus_reset = wr_one(port_wr, avs_byteenable, avs_writedata, `UHPC_B_BUS_RESET);

  always_comb begin
    nxt_ack   = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !ack_ff) begin
      nxt_rdata = `UHPC_RESET_WORD;
      case (avs_address)
        `UHPC_OFS_PORT: begin
          nxt_rdata[`UHPC_B_CONN_STATE]                = connect_state;
          nxt_rdata[`UHPC_B_CONN_DET]                  = connect_detected_flag_ff;
          nxt_rdata[`UHPC_B_PORT_EN]                   = port_enabled_ff;
          nxt_rdata[`UHPC_B_EN_CHG]                    = enable_change_flag_ff;
          nxt_rdata[`UHPC_B_RESUME]                    = resume_drive_ff;
          nxt_rdata[`UHPC_B_SUSPEND]                   = port_suspend_ff;
          nxt_rdata[`UHPC_B_BUS_RESET]                 = bus_reset_drive_ff;
          nxt_rdata[`UHPC_B_LINE_DP]                   = dp_in;
          nxt_rdata[`UHPC_B_LINE_DM]                   = dm_in;
          nxt_rdata[`UHPC_B_POWER]                     = power_ff;
          nxt_rdata[`UHPC_B_SPEED_LO +: 2]             = attached_speed;
        end
        `UHPC_OFS_INT_STAT: nxt_rdata[`UHPC_INT_W-1:0] = int_stat_ff;
        `UHPC_OFS_INT_MASK: nxt_rdata[`UHPC_INT_W-1:0] = int_mask_ff;
        default:            nxt_rdata                  = `UHPC_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= `UHPC_RESET_WORD;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;

  // port control and status
  always_comb begin
    // power is only a flag, no supply is switched
    nxt_power = wr_rw(port_wr, avs_byteenable, avs_writedata, `UHPC_B_POWER, power_ff);

    nxt_bus_reset_drive = wr_rw(port_wr, avs_byteenable, avs_writedata,
                                `UHPC_B_BUS_RESET, bus_reset_drive_ff);
    nxt_resume_drive    = wr_rw(port_wr, avs_byteenable, avs_writedata,
                                `UHPC_B_RESUME, resume_drive_ff);

    reset_start = nxt_bus_reset_drive & ~bus_reset_drive_ff;
    reset_done  = bus_reset_drive_ff & ~nxt_bus_reset_drive;

    // suspend is set by software, cleared only by the listed events
    nxt_port_suspend = port_suspend_ff;
    if (w1_suspend) begin
      nxt_port_suspend = 1'b1;
    end
    if (w1_bus_reset || w1_resume || wake_pulse || disc_pulse) begin
      nxt_port_suspend = 1'b0;
    end

    // enable: set by end of bus reset only
    nxt_port_enabled = port_enabled_ff;
    if (reset_done && connect_state) begin
      nxt_port_enabled = 1'b1;
    end
    if (disc_pulse || w1_port_en) begin
      nxt_port_enabled = 1'b0;
    end

    enable_change = nxt_port_enabled ^ port_enabled_ff;
    nxt_enable_change_flag = enable_change |
      (enable_change_flag_ff & ~w1_en_chg);
    nxt_connect_detected_flag = conn_pulse |
      (connect_detected_flag_ff & ~w1_conn_det);
  end

  // interrupt status, mask and output; a set wins over a clear
  always_comb begin
    nxt_int_mask = int_mask_ff;
    if (mask_wr && avs_byteenable[0]) begin
      nxt_int_mask = avs_writedata[`UHPC_INT_W-1:0];
    end
    nxt_int_stat = int_stat_ff;
    if (stat_wr && avs_byteenable[0]) begin
      nxt_int_stat = int_stat_ff & ~avs_writedata[`UHPC_INT_W-1:0];
    end
    if (reset_start || enable_change || conn_pulse) begin
      nxt_int_stat[`UHPC_I_PORT_EVT] = 1'b1;
    end
    if (disc_pulse) begin
      nxt_int_stat[`UHPC_I_DISCONNECT] = 1'b1;
    end
    if (wake_pulse) begin
      nxt_int_stat[`UHPC_I_WAKEUP] = 1'b1;
    end
    nxt_irq = |(nxt_int_stat & nxt_int_mask);
  end

  // line drive: bus reset is se0, resume is k, otherwise released
  always_comb begin
    nxt_dp   = 1'b0;
    nxt_dm   = 1'b0;
    nxt_oe_n = 1'b1;
    if (nxt_bus_reset_drive) begin
      nxt_oe_n = 1'b0;
    end else if (nxt_resume_drive) begin
      nxt_oe_n = 1'b0;
      nxt_dp   = (attached_speed == `UHPC_SPEED_LOW);
      nxt_dm   = (attached_speed != `UHPC_SPEED_LOW);
    end
    nxt_sof = nxt_port_enabled & ~nxt_port_suspend & ~nxt_bus_reset_drive;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_enabled_ff          <= 1'b0;
      enable_change_flag_ff    <= 1'b0;
      connect_detected_flag_ff <= 1'b0;
      resume_drive_ff          <= 1'b0;
      port_suspend_ff          <= 1'b0;
      bus_reset_drive_ff       <= 1'b0;
      power_ff                 <= 1'b0;
    end else begin
      port_enabled_ff          <= nxt_port_enabled;
      enable_change_flag_ff    <= nxt_enable_change_flag;
      connect_detected_flag_ff <= nxt_connect_detected_flag;
      resume_drive_ff          <= nxt_resume_drive;
      port_suspend_ff          <= nxt_port_suspend;
      bus_reset_drive_ff       <= nxt_bus_reset_drive;
      power_ff                 <= nxt_power;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_stat_ff              <= '0;
      int_mask_ff              <= '0;
      irq_ff                   <= 1'b0;
    end else begin
      int_stat_ff              <= nxt_int_stat;
      int_mask_ff              <= nxt_int_mask;
      irq_ff                   <= nxt_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dp_ff                    <= 1'b0;
      dm_ff                    <= 1'b0;
      oe_n_ff                  <= 1'b1;
      sof_ff                   <= 1'b0;
    end else begin
      dp_ff                    <= nxt_dp;
      dm_ff                    <= nxt_dm;
      oe_n_ff                  <= nxt_oe_n;
      sof_ff                   <= nxt_sof;
    end
  end

  assign irq           = irq_ff;
  assign dp_out        = dp_ff;
  assign dm_out        = dm_ff;
  assign d_oe_n        = oe_n_ff;
  assign sof_enable    = sof_ff;
  assign port_power_on = power_ff;

endmodule // uhpc_port_ctrl

/* testbench/uhpc_port_ctrl_props.sv */
// assertions on the usb host port control block
`timescale 1ns/1ps
`include "uhpc_params.svh"

module uhpc_port_ctrl_props
  import uhpc_pkg::*;
#(
  parameter int DEB_CYC  = 4,
  parameter int DISC_CYC = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // interrupt, lines and status
  input  wire logic        irq,
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  input  wire logic        dp_out,
  input  wire logic        dm_out,
  input  wire logic        d_oe_n,
  input  wire logic        sof_enable,
  input  wire logic        port_power_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic        wr0;
  logic        rd0;
  logic [31:0] wd;
  assign wd  = avs_writedata;
  assign wr0 = avs_write && !avs_waitrequest && avs_address == `UHPC_OFS_PORT
               && avs_byteenable == 4'hf;
  assign rd0 = avs_read && !avs_waitrequest && avs_address == `UHPC_OFS_PORT;

  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  property p_rst_drv;
    wr0 && wd[8] |=> (!d_oe_n && !dp_out && !dm_out) [*2];
  endproperty
  a_rst_drv: assert property (p_rst_drv) else $error("no bus reset drive");
  property p_rst_hold;
    !d_oe_n && !dp_out && !dm_out && !avs_write |=> !d_oe_n && !dp_out && !dm_out;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("bus reset dropped");
  property p_resume;
    wr0 && wd[6] && !wd[8] |=> !d_oe_n && dp_out != dm_out;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume drive");
  property p_release;
    wr0 && !wd[6] && !wd[8] |=> d_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("lines not released");
  property p_suspend;
    wr0 && wd[7] && !wd[6] && !wd[8] |=> ##1 !sof_enable;
  endproperty
  a_suspend: assert property (p_suspend) else $error("frame starts in suspend");
  property p_power;
    wr0 |=> port_power_on == $past(wd[12]);
  endproperty
  a_power: assert property (p_power) else $error("power bit not copied");
  property p_rsvd;
    rd0 |-> (avs_readdata & 32'hfff9_e230) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_speed;
    rd0 |-> avs_readdata[18:17] != 2'h3 && (!avs_readdata[0] || avs_readdata[18:17] != 2'h0);
  endproperty
  a_speed: assert property (p_speed) else $error("bad speed code");
  property p_unmap;
    avs_read && !avs_waitrequest && !(avs_address inside {4'h0, 4'h4, 4'h8})
      |-> avs_readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // uhpc_port_ctrl_props

bind uhpc_port_ctrl uhpc_port_ctrl_props #(.DEB_CYC(DEB_CYC), .DISC_CYC(DISC_CYC)) u_props (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out), .d_oe_n(d_oe_n),
  .sof_enable(sof_enable), .port_power_on(port_power_on));

/* testbench/uhpc_usb_dev_model.sv */
// attached usb device model with line resolution
`timescale 1ns/1ps

module uhpc_usb_dev_model (
  // device behaviour
  input  wire logic attach,
  input  wire logic low_speed,
  input  wire logic wake,
  // host drive
  input  wire logic dp_out,
  input  wire logic dm_out,
  input  wire logic d_oe_n,
  // resolved lines
  output logic      dp_in,
  output logic      dm_in
);
  logic j_dp;
  always_comb begin
    j_dp = !low_speed ^ wake;
    if (!d_oe_n) begin
      dp_in = dp_out;
      dm_in = dm_out;
    end else if (!attach) begin
      dp_in = 1'b0;
      dm_in = 1'b0;
    end else begin
      dp_in = j_dp;
      dm_in = !j_dp;
    end
  end
endmodule // uhpc_usb_dev_model

/* testbench/uhpc_port_ctrl_tb_top.sv */
// self-checking bench of the usb host port control block
`timescale 1ns/1ps
`include "uhpc_params.svh"
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); \
  end \
end

module uhpc_port_ctrl_tb_top
  import uhpc_pkg::*;
;
  typedef struct {logic [31:0] e; logic [31:0] m;} uhpc_note_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        dp_in;
  logic        dm_in;
  logic        dp_out;
  logic        dm_out;
  logic        d_oe_n;
  logic        sof_enable;
  logic        port_power_on;
  logic        attach = 1'b0;
  logic        low_speed = 1'b0;
  logic        wake = 1'b0;
  logic [31:0] ln;
  int          n_fail = 0;
  int          compares = 0;
  uhpc_note_t  q[$];

  always #4 clk = ~clk;

  uhpc_port_ctrl #(.CNT_W(12), .DEB_CYC(4), .DISC_CYC(4)) uhpc_port_ctrl_inst (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dm_out(dm_out), .d_oe_n(d_oe_n),
    .sof_enable(sof_enable), .port_power_on(port_power_on));

  uhpc_usb_dev_model uhpc_usb_dev_model_inst (
    .attach(attach), .low_speed(low_speed), .wake(wake), .dp_out(dp_out),
    .dm_out(dm_out), .d_oe_n(d_oe_n), .dp_in(dp_in), .dm_in(dm_in));

  task automatic test_done;
    // a read note never answered is a mismatch
    if (q.size() != 0)
      n_fail++;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      test_done();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e & m, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk) begin
    uhpc_note_t nt;
    if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0) begin
      nt = q.pop_front();
      `CHK("readdata", nt.e, avs_readdata & nt.m)
    end
  end

  initial begin
    logic [31:0] r;
    void'($urandom(32'h0ebafb0c));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`UHPC_OFS_PORT, 32'h0, 32'hffff_ffff);
    rd(`UHPC_OFS_INT_STAT, 32'h0, 32'hffff_ffff);
    r = $urandom();
    wr(4'hc, r);
    rd(4'hc, 32'h0, 32'hffff_ffff);
    wr(`UHPC_OFS_PORT, (r & 32'hfff9_e230) | 32'h1000);
    settle;
    `CHK("port_power_on", 1'b1, port_power_on)
    rd(`UHPC_OFS_PORT, 32'h1000, 32'hffff_ffff);
    wr(`UHPC_OFS_INT_MASK, 32'h7);
    for (int i = 0; i < 2; i++) begin
      low_speed <= i[0];
      attach    <= 1'b1;
      ln = i[0] ? 32'h4_0800 : 32'h2_0400;
      repeat (10) @(posedge clk);
      rd(`UHPC_OFS_PORT, 32'h1003 | ln, 32'hffff_ffff);
      settle;
      `CHK("irq", 1'b1, irq)
      wr(`UHPC_OFS_INT_MASK, 32'h0);
      settle;
      `CHK("irq", 1'b0, irq)
      wr(`UHPC_OFS_INT_MASK, 32'h7);
      rd(`UHPC_OFS_INT_STAT, 32'h1, 32'h1);
      wr(`UHPC_OFS_INT_STAT, 32'h7);
      wr(`UHPC_OFS_PORT, 32'h1002);
      settle;
      `CHK("irq", 1'b0, irq)
      rd(`UHPC_OFS_PORT, 32'h1001 | ln, 32'hffff_ffff);
      wr(`UHPC_OFS_PORT, 32'h1100);
      settle;
      `CHK("d_oe_n", 1'b0, d_oe_n)
      `CHK("dp_out", 1'b0, dp_out)
      `CHK("sof_enable", 1'b0, sof_enable)
      rd(`UHPC_OFS_INT_STAT, 32'h1, 32'h1);
      wr(`UHPC_OFS_PORT, 32'h1000);
      settle;
      `CHK("d_oe_n", 1'b1, d_oe_n)
      `CHK("sof_enable", 1'b1, sof_enable)
      rd(`UHPC_OFS_PORT, 32'h100d | ln, 32'hffff_ffff);
      wr(`UHPC_OFS_PORT, 32'h1008);
      wr(`UHPC_OFS_INT_STAT, 32'h7);
      wr(`UHPC_OFS_PORT, 32'h1080);
      settle;
      `CHK("sof_enable", 1'b0, sof_enable)
      rd(`UHPC_OFS_PORT, 32'h1080, 32'h1c0);
      wr(`UHPC_OFS_PORT, 32'h1040);
      settle;
      `CHK("d_oe_n", 1'b0, d_oe_n)
      `CHK("dp_out", i[0], dp_out)
      `CHK("dm_out", !i[0], dm_out)
      rd(`UHPC_OFS_PORT, 32'h1040, 32'h1c0);
      wr(`UHPC_OFS_PORT, 32'h1000);
      settle;
      `CHK("sof_enable", 1'b1, sof_enable)
      wr(`UHPC_OFS_PORT, 32'h1080);
      wake <= 1'b1;
      repeat (8) @(posedge clk);
      wake <= 1'b0;
      rd(`UHPC_OFS_PORT, 32'h1000, 32'h1c0);
      rd(`UHPC_OFS_INT_STAT, 32'h4, 32'h4);
      wr(`UHPC_OFS_INT_STAT, 32'h7);
      wr(`UHPC_OFS_PORT, 32'h1004);
      rd(`UHPC_OFS_PORT, 32'h8, 32'hc);
      wr(`UHPC_OFS_PORT, 32'h100c);
      rd(`UHPC_OFS_PORT, 32'h0, 32'hc);
      wr(`UHPC_OFS_PORT, 32'h1100);
      wr(`UHPC_OFS_PORT, 32'h1000);
      wr(`UHPC_OFS_PORT, 32'h1008);
      wr(`UHPC_OFS_INT_STAT, 32'h7);
      wr(`UHPC_OFS_PORT, 32'h1080);
      attach <= 1'b0;
      repeat (10) @(posedge clk);
      rd(`UHPC_OFS_PORT, 32'h1008, 32'hfff9_ffff);
      rd(`UHPC_OFS_INT_STAT, 32'h3, 32'h3);
      wr(`UHPC_OFS_INT_STAT, 32'h7);
      wr(`UHPC_OFS_PORT, 32'h1008);
    end
    test_done();
  end
endmodule // uhpc_port_ctrl_tb_top
